// ==== pkg/digipot_defs.svh ====
// constants for the dual-channel digital potentiometer command decoder
// assumes a 25 MHz core clock and a 16-bit command word arriving over a two-wire serial link
`ifndef DIGIPOT_DEFS_SVH
`define DIGIPOT_DEFS_SVH

// command nibbles, upper four bits of the command byte
`define CMD_NOP        4'h0
`define CMD_WR_WIPER   4'h1
`define CMD_WR_INPUT   4'h2
`define CMD_READBACK   4'h3
`define CMD_STEP       4'h4
`define CMD_SHIFT      4'h5
`define CMD_XFER       4'h6
`define CMD_NV_COPY    4'h7
`define CMD_NV_WRITE   4'h8
`define CMD_SCALE      4'h9
`define CMD_SW_RESET   4'hB
`define CMD_SHUTDOWN   4'hC
`define CMD_CONTROL    4'hD

// address field positions
`define ADR_ALL  3
`define ADR_AW   2
`define ADR_NV1  1
`define ADR_CH   0

// control register fields and reset value
`define CTL_WIPER_WE  0
`define CTL_NV_WE     1
`define CTL_LINEAR    2
`define CTL_BURST     3
`define CTL_RESET     4'h3

// readback source select
`define RB_INPUT  2'h0
`define RB_NV     2'h1
`define RB_CTL    2'h2
`define RB_WIPER  2'h3

// data byte constants
`define MIDSCALE    8'h80
`define FULL_SCALE  8'hFF
`define ZERO_SCALE  8'h00
`define ONE_STEP    8'h01

// timing
`define CLK_MHZ         25
`define RELOAD_TIME_US  30
`define RELOAD_CYCLES   (`RELOAD_TIME_US * `CLK_MHZ)

`endif

// ==== pkg/digipot_pkg.sv ====
// types for the digital potentiometer command decoder
// assumes nothing beyond the defs header
package digipot_pkg;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_ADDR = 3'b001,
    LINK_ACK  = 3'b010,
    LINK_WR   = 3'b011,
    LINK_RD   = 3'b100,
    LINK_MACK = 3'b101
  } link_state_t;
endpackage

// ==== core/digipot_command_decoder.sv ====
// serial slave, command decoder and wiper/nonvolatile storage of a dual-channel digital potentiometer
// assumes scl/sda and the pins are asynchronous to clk and scl runs well below clk/6
`timescale 1ns/1ps
`include "digipot_defs.svh"

// Summary of operation
// R01: command word is 16 bits, MSB first: 4 command, 4 address, 8 data bits
// R02: one input register per wiper; command 2 loads it, command 3 reads it
// R03: command 6 copies input registers to the addressed wipers, all entries at once with address bit 3; the code selects only entries 0 and 2 outside linear mode
// R04: every new wiper value is also written into its input register
// R05: command 4 steps wiper up by one when D0 set, down by one when D0 clear
// R06: command 5 doubles wiper by left shift when D0 set, halves by right shift when D0 clear
// R07: double of zero gives one, of top bit saturates; halve of one gives zero
// R08: command 13 writes low four bits to control; D2 selects linear gain mode
// R09: linear mode adds A-to-wiper registers; mode switch keeps wiper contents
// R10: linear mode when independent pin high or control D2 set
// R11: at power-up each setting is loaded from its stored location
// R12: command 9 enters or leaves top (D7 set) or bottom (D7 clear) scale by D0
// R13: scale state exits on exit command, any wiper load, or shutdown entry
// R14: with burst bit set every following byte is data for the same command
// R15: burst stays on across stop and restart, cleared only by control write or srst
// R16: command 11 or reset pin low pulse reloads wipers from storage in 30 us
// R17: storage holds midscale initially, so wipers start at midscale
// R18: command 12 enters or leaves shutdown by D0, commands still accepted
// R19: shutdown opens A and ties wiper to B, or sets string high impedance
// R20: control D0 clear freezes the wiper, set allows interface updates
// R21: control D1 clear blocks all programming of nonvolatile storage
// R22: a protected wiper only accepts a copy from nonvolatile storage
// R23: command 7 with D0 set stores the wiper into nonvolatile storage; with D0 clear it recalls it
// R24: after a storage write the bus is ignored until the write cycle ends
// R25: command 8 writes the data byte straight into a storage location
// R26: readback source: input, storage, control or wiper, sent in next read
// R27: address bit 3 means all; bit 0 channel, bit 2 A-to-wiper register; the code makes bit 3 select only entries 0 and 2 outside linear mode
module digipot_command_decoder #(
  parameter int NV_WRITE_CYCLES = 250
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] dev_addr,
  input wire logic independent_mode_pin,
  input wire logic reset_pin_n,
  output wire logic [3:0][7:0] wiper_setting_register,
  output logic [3:0] control_out,
  output logic linear_mode,
  output wire logic [1:0] top_scale_state,
  output wire logic [1:0] bottom_scale_state,
  output logic [3:0] shutdown_state,
  output logic [1:0] pot_shutdown_switch,
  output logic [3:0] string_hiz,
  output logic nv_busy
);
  // input synchronisers
  logic [1:0] scl_sync, sda_sync, independent_mode_pin_sync, rst_sync;
  logic [6:0] addr_s1, addr_s2;
  logic scl_prev, sda_prev, rst_prev;
  always_ff @(posedge clk) begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    independent_mode_pin_sync <= {independent_mode_pin_sync[0], independent_mode_pin};
    rst_sync <= {rst_sync[0], reset_pin_n};
    addr_s1 <= dev_addr;
    addr_s2 <= addr_s1;
    scl_prev <= scl_sync[1];
    sda_prev <= sda_sync[1];
    rst_prev <= rst_sync[1];
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, rst_pin_fall;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det = scl_s & scl_prev & ~sda_prev & sda_s;
  assign rst_pin_fall = rst_prev & ~rst_sync[1];

  // serial link state
  digipot_pkg::link_state_t link_reg;
  logic [3:0] bit_cnt;
  logic [7:0] shift_reg, tx_reg, rb_reg;
  logic rd_mode, rd_second, more_rd, byte_pulse;
  logic [3:0] ctrl_reg;
  logic nv_busy_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      link_reg <= digipot_pkg::LINK_IDLE;
      bit_cnt <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_mode <= 1'b0;
      rd_second <= 1'b0;
      more_rd <= 1'b0;
      byte_pulse <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      byte_pulse <= 1'b0;
      if (start_det) begin
        link_reg <= digipot_pkg::LINK_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        link_reg <= digipot_pkg::LINK_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (link_reg)
          digipot_pkg::LINK_ADDR, digipot_pkg::LINK_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s}; // R01
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (link_reg == digipot_pkg::LINK_WR) begin
                sda_oe <= 1'b1;
                byte_pulse <= 1'b1;
                link_reg <= digipot_pkg::LINK_ACK;
              end else if (shift_reg[7:1] == addr_s2 && !nv_busy_reg) begin // R24
                sda_oe <= 1'b1;
                rd_mode <= shift_reg[0];
                rd_second <= 1'b0;
                link_reg <= digipot_pkg::LINK_ACK;
              end else begin
                link_reg <= digipot_pkg::LINK_IDLE;
              end
            end
          end
          digipot_pkg::LINK_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rd_mode) begin
                // high byte of a readback word is zero
                tx_reg <= 8'h00;
                sda_oe <= 1'b1;
                link_reg <= digipot_pkg::LINK_RD;
              end else begin
                sda_oe <= 1'b0;
                link_reg <= digipot_pkg::LINK_WR;
              end
            end
          end
          digipot_pkg::LINK_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe <= 1'b0;
                link_reg <= digipot_pkg::LINK_MACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe <= ~tx_reg[6];
              end
            end
          end
          digipot_pkg::LINK_MACK: begin
            if (scl_rise) begin
              more_rd <= ~sda_s & ~rd_second;
            end else if (scl_fall) begin
              if (more_rd) begin
                rd_second <= 1'b1;
                bit_cnt <= 4'h0;
                tx_reg <= rb_reg; // R26
                sda_oe <= ~rb_reg[7];
                link_reg <= digipot_pkg::LINK_RD;
              end else begin
                link_reg <= digipot_pkg::LINK_IDLE;
              end
            end
          end
          default: begin
            link_reg <= digipot_pkg::LINK_IDLE;
          end
        endcase
      end
    end
  end

  // byte pairing into commands
  logic byte_idx, exec_valid;
  logic [7:0] cmd_reg, data_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      byte_idx <= 1'b0;
      exec_valid <= 1'b0;
      cmd_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      exec_valid <= 1'b0;
      if (start_det) begin
        byte_idx <= 1'b0; // R14
      end else if (byte_pulse) begin
        if (!byte_idx) begin
          cmd_reg <= shift_reg; // R01
          byte_idx <= 1'b1;
        end else begin
          data_reg <= shift_reg;
          exec_valid <= 1'b1;
          byte_idx <= ctrl_reg[`CTL_BURST]; // R14
        end
      end
    end
  end

  logic [3:0] op, adr;
  logic [7:0] d;
  assign op = cmd_reg[7:4];
  assign adr = cmd_reg[3:0];
  assign d = data_reg;

  logic lin;
  assign lin = independent_mode_pin_sync[1] | ctrl_reg[`CTL_LINEAR]; // R10

  // target entries, index = channel*2 + aw
  logic [3:0] sel;
  logic [1:0] idx, nv_idx;
  assign idx = {adr[`ADR_CH], adr[`ADR_AW]};
  assign nv_idx = {adr[`ADR_NV1], adr[`ADR_CH]};
  always_comb begin
    sel = 4'h0;
    if (adr[`ADR_ALL]) begin
      sel = lin ? 4'hF : 4'h5; // R27
    end else if (lin || !adr[`ADR_AW]) begin
      sel[idx] = 1'b1; // R27
    end
  end

  // control register and readback latch
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `CTL_RESET;
    end else if (exec_valid && op == `CMD_CONTROL) begin
      ctrl_reg <= d[3:0]; // R08 R15 R20 R21
    end
  end

  logic [7:0] wip [4];
  logic [7:0] inreg [4];
  logic [7:0] nv_mem [4];
  always_ff @(posedge clk) begin
    if (srst) begin
      rb_reg <= 8'h00;
    end else if (exec_valid && op == `CMD_READBACK) begin
      case (d[1:0]) // R26
        `RB_INPUT: rb_reg <= inreg[idx]; // R02
        `RB_NV: rb_reg <= nv_mem[nv_idx];
        `RB_CTL: rb_reg <= {4'h0, ctrl_reg};
        default: rb_reg <= wip[idx];
      endcase
    end
  end

  // reload timer for reset command, reset pin and power-up
  logic [9:0] reload_cnt;
  logic reload_done;
  assign reload_done = (reload_cnt == 10'h001);
  always_ff @(posedge clk) begin
    if (srst) begin
      reload_cnt <= 10'(`RELOAD_CYCLES); // R11
    end else if ((exec_valid && op == `CMD_SW_RESET) || rst_pin_fall) begin
      reload_cnt <= 10'(`RELOAD_CYCLES); // R16
    end else if (reload_cnt != 10'h000) begin
      reload_cnt <= reload_cnt - 10'h001;
    end
  end

  // storage write cycle
  logic nv_prog_ok, nv_start;
  logic [15:0] nv_cnt;
  assign nv_prog_ok = exec_valid && ctrl_reg[`CTL_NV_WE]; // R21
  assign nv_start = nv_prog_ok &&
                    ((op == `CMD_NV_COPY && d[0] && sel != 4'h0) || op == `CMD_NV_WRITE);
  always_ff @(posedge clk) begin
    if (srst) begin
      nv_cnt <= 16'h0000;
      nv_busy_reg <= 1'b0;
    end else if (nv_start) begin
      nv_cnt <= 16'(NV_WRITE_CYCLES);
      nv_busy_reg <= 1'b1; // R24
    end else if (nv_cnt != 16'h0000) begin
      nv_cnt <= nv_cnt - 16'h0001;
      nv_busy_reg <= (nv_cnt != 16'h0001);
    end
  end

  // per-entry wiper, input register, storage and shutdown
  logic [3:0] load;
  logic wp_ok;
  assign wp_ok = exec_valid && ctrl_reg[`CTL_WIPER_WE]; // R20
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_entry
      logic [7:0] nxt, cur;
      assign cur = wip[gi];
      always_comb begin
        nxt = cur;
        load[gi] = 1'b0;
        if (reload_done) begin
          nxt = nv_mem[gi]; // R16
          load[gi] = 1'b1;
        end else if (exec_valid && op == `CMD_NV_COPY && !d[0] && sel[gi]) begin
          nxt = nv_mem[gi]; // R22
          load[gi] = 1'b1;
        end else if (wp_ok && sel[gi]) begin
          case (op)
            `CMD_WR_WIPER: begin
              nxt = d;
              load[gi] = 1'b1;
            end
            `CMD_STEP: begin // R05
              nxt = d[0] ? ((cur == `FULL_SCALE) ? cur : cur + `ONE_STEP)
                         : ((cur == `ZERO_SCALE) ? cur : cur - `ONE_STEP);
              load[gi] = 1'b1;
            end
            `CMD_SHIFT: begin // R06
              if (d[0]) begin
                nxt = (cur == `ZERO_SCALE) ? `ONE_STEP : (cur[7] ? `FULL_SCALE : {cur[6:0], 1'b0}); // R07
              end else begin
                nxt = {1'b0, cur[7:1]}; // R07
              end
              load[gi] = 1'b1;
            end
            `CMD_XFER: begin
              nxt = inreg[gi]; // R03
              load[gi] = 1'b1;
            end
            default: begin
              nxt = cur;
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          wip[gi] <= `MIDSCALE; // R17
          inreg[gi] <= `MIDSCALE;
          nv_mem[gi] <= `MIDSCALE; // R17
          shutdown_state[gi] <= 1'b0;
        end else begin
          if (load[gi]) begin
            wip[gi] <= nxt; // R09
            inreg[gi] <= nxt; // R04
          end else if (exec_valid && op == `CMD_WR_INPUT && sel[gi]) begin
            inreg[gi] <= d; // R02
          end
          if (nv_prog_ok && op == `CMD_NV_COPY && d[0] && sel[gi]) begin
            nv_mem[gi] <= wip[gi]; // R23
          end else if (nv_prog_ok && op == `CMD_NV_WRITE && nv_idx == 2'(gi)) begin
            nv_mem[gi] <= d; // R25
          end
          if (exec_valid && op == `CMD_SHUTDOWN && sel[gi]) begin
            shutdown_state[gi] <= d[0]; // R18
          end
        end
      end
      assign wiper_setting_register[gi] = wip[gi];
    end

    // per-channel top and bottom scale
    for (gi = 0; gi < 2; gi++) begin : g_chan
      logic top_reg, bot_reg, hit, loaded, sd_entry;
      assign hit = exec_valid && (sel[2*gi] || sel[2*gi+1]);
      assign loaded = load[2*gi] || load[2*gi+1];
      assign sd_entry = hit && op == `CMD_SHUTDOWN && d[0];
      always_ff @(posedge clk) begin
        if (srst) begin
          top_reg <= 1'b0;
          bot_reg <= 1'b0;
        end else if (hit && op == `CMD_SCALE) begin
          top_reg <= d[7] ? d[0] : 1'b0; // R12
          bot_reg <= d[7] ? 1'b0 : d[0]; // R12
        end else if (loaded || sd_entry) begin
          top_reg <= 1'b0; // R13
          bot_reg <= 1'b0; // R13
        end
      end
      assign top_scale_state[gi] = top_reg;
      assign bottom_scale_state[gi] = bot_reg;
    end
  endgenerate

  // registered switch controls
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out <= 1'b0;
      control_out <= `CTL_RESET;
      linear_mode <= 1'b0;
      pot_shutdown_switch <= 2'h0;
      string_hiz <= 4'h0;
      nv_busy <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      control_out <= ctrl_reg;
      linear_mode <= lin; // R10
      pot_shutdown_switch <= {shutdown_state[2], shutdown_state[0]} & {2{~lin}}; // R19
      string_hiz <= shutdown_state & {4{lin}}; // R19
      nv_busy <= nv_busy_reg;
    end
  end
endmodule

// ==== verification/digipot_chk.sv ====
// assertion checker on the potentiometer decoder ports
// assumes the decoder's clk and active-high synchronous srst
`timescale 1ns/1ps
`include "digipot_defs.svh"
module digipot_chk #(
  parameter int NV_WRITE_CYCLES = 250
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [3:0][7:0] wiper_setting_register,
  input wire logic [3:0] control_out,
  input wire logic linear_mode,
  input wire logic [1:0] top_scale_state,
  input wire logic [1:0] bottom_scale_state,
  input wire logic [3:0] shutdown_state,
  input wire logic [1:0] pot_shutdown_switch,
  input wire logic [3:0] string_hiz,
  input wire logic nv_busy
);
  localparam int BMIN = NV_WRITE_CYCLES - 2;
  localparam int BMAX = NV_WRITE_CYCLES + 2;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_sda_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_linear_from_ctl: assert property (control_out[2] |-> linear_mode) else $error("bit2 without linear");
  a_scale_exclusive: assert property ((top_scale_state & bottom_scale_state) == 2'b00) else $error("both scales");
  a_shut_mode_split: assert property (pot_shutdown_switch[0] == ($past(shutdown_state[0]) && !linear_mode))
    else $error("pot shutdown switch wrong");
  a_hiz_in_linear: assert property (string_hiz[1] == ($past(shutdown_state[1]) && linear_mode))
    else $error("string high impedance wrong");
  a_busy_no_ack: assert property (nv_busy && $past(nv_busy) |-> !$rose(sda_oe)) else $error("ack while busy");
  a_busy_holds: assert property ($rose(nv_busy) |-> nv_busy[*8]) else $error("busy too short");
  a_busy_ends: assert property ($rose(nv_busy) |-> ##[BMIN:BMAX] $fell(nv_busy)) else $error("busy length");
  a_scale_keeps_wiper: assert property ($rose(top_scale_state[0]) |-> $stable(wiper_setting_register[0]))
    else $error("scale changed wiper");
  a_load_exits_scale: assert property ($changed(wiper_setting_register[0]) |-> ##[0:2] !top_scale_state[0])
    else $error("scale kept after load");
  a_shut_keeps_wiper: assert property ($rose(shutdown_state[0]) |-> $stable(wiper_setting_register))
    else $error("shutdown changed wiper");
  a_ctl_reset_value: assert property ($fell(srst) |-> control_out == `CTL_RESET) else $error("control reset");
  c_top: cover property ($rose(top_scale_state[0]));
  c_hiz: cover property ($rose(string_hiz[1]));
  c_busy: cover property ($fell(nv_busy));
endmodule
bind digipot_command_decoder digipot_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_i (
  .clk(clk), .srst(srst), .sda_out(sda_out), .sda_oe(sda_oe),
  .wiper_setting_register(wiper_setting_register), .control_out(control_out),
  .linear_mode(linear_mode), .top_scale_state(top_scale_state),
  .bottom_scale_state(bottom_scale_state), .shutdown_state(shutdown_state),
  .pot_shutdown_switch(pot_shutdown_switch), .string_hiz(string_hiz), .nv_busy(nv_busy));

// ==== verification/i2c_master_model.sv ====
// two-wire serial master model, eight core clocks per bit
// assumes an open-drain data line with pull-up, scl idle high between frames
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda_line
);
  logic sda_m = 1'b1;
  initial scl = 1'b1;
  // released line reads high through the pull-up
  assign sda_line = sda_m & ~sda_oe;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sda_m <= 1'b0;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_m <= 1'b1;
    wt(4);
  endtask
  // data changes only while scl is low
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda_line;
    wt(2);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic ak_tx, output logic [7:0] rx, output logic ak_rx);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ak_tx, ak_rx);
  endtask
endmodule

// ==== verification/digipot_command_decoder_tb_top.sv ====
// self-checking bench for the potentiometer command decoder
// assumes the serial master model and the bound port checker
`timescale 1ns/1ps
`include "digipot_defs.svh"
module digipot_command_decoder_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ind_pin = 1'b0;
  logic rst_n = 1'b1;
  logic [6:0] dev_addr = 7'h2A;
  logic scl, sda, sda_out, sda_oe, lin, busy, ak;
  logic [3:0][7:0] wp;
  logic [3:0] ctl, shut, hiz;
  logic [1:0] top, bot, psw;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  digipot_command_decoder #(.NV_WRITE_CYCLES(200)) uut (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_addr(dev_addr), .independent_mode_pin(ind_pin), .reset_pin_n(rst_n),
    .wiper_setting_register(wp), .control_out(ctl), .linear_mode(lin), .top_scale_state(top),
    .bottom_scale_state(bot), .shutdown_state(shut), .pot_shutdown_switch(psw),
    .string_hiz(hiz), .nv_busy(busy));
  i2c_master_model m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_line(sda));
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic send(input logic [3:0] cmd, input logic [3:0] adr, input logic [7:0] d, input int n = 1);
    logic [7:0] rx;
    m.start();
    m.xbyte({dev_addr, 1'b0}, 1'b1, rx, ak);
    m.xbyte({cmd, adr}, 1'b1, rx, ak);
    repeat (n) m.xbyte(d, 1'b1, rx, ak);
    m.stop();
    m.wt(4);
  endtask
  task automatic rd(input logic [3:0] adr, input logic [7:0] sel, input logic [7:0] exp);
    logic [7:0] rx;
    send(`CMD_READBACK, adr, sel);
    m.start();
    m.xbyte({dev_addr, 1'b1}, 1'b1, rx, ak);
    m.xbyte(8'hFF, 1'b0, rx, ak);
    m.xbyte(8'hFF, 1'b1, rx, ak);
    m.stop();
    chk(rx, exp);
  endtask
  task automatic poll(input logic [6:0] a);
    logic [7:0] rx;
    m.start();
    m.xbyte({a, 1'b0}, 1'b1, rx, ak);
    m.stop();
  endtask
  task automatic t_power();
    for (int i = 0; i < 4; i++) chk(wp[i], `MIDSCALE);
    chk({4'h0, ctl}, {4'h0, `CTL_RESET});
    chkb(lin, 1'b0);
    chkb(sda_out, 1'b0);
    $display("t_power done");
  endtask
  task automatic t_shift();
    send(`CMD_WR_WIPER, 4'h0, 8'h00);
    send(`CMD_SHIFT, 4'h0, 8'h01);
    chk(wp[0], 8'h01);
    send(`CMD_WR_WIPER, 4'h0, 8'h80);
    send(`CMD_SHIFT, 4'h0, 8'h01);
    chk(wp[0], 8'hFF);
    send(`CMD_SHIFT, 4'h0, 8'h00);
    chk(wp[0], 8'h7F);
    send(`CMD_WR_WIPER, 4'h0, 8'h01);
    send(`CMD_SHIFT, 4'h0, 8'h00);
    chk(wp[0], 8'h00);
    $display("t_shift done");
  endtask
  task automatic t_input();
    send(`CMD_WR_INPUT, 4'h1, 8'h33);
    chk(wp[2], `MIDSCALE);
    send(`CMD_XFER, 4'h8, 8'h00);
    chk(wp[2], 8'h33);
    chk(wp[0], 8'h00);
    send(`CMD_WR_WIPER, 4'h0, 8'h5A);
    rd(4'h0, 8'h00, 8'h5A);
    rd(4'h0, 8'h02, {4'h0, `CTL_RESET});
    $display("t_input done");
  endtask
  task automatic t_step();
    send(`CMD_STEP, 4'h0, 8'h00);
    chk(wp[0], 8'h59);
    send(`CMD_STEP, 4'h8, 8'h01);
    chk(wp[0], 8'h5A);
    chk(wp[2], 8'h34);
    $display("t_step done");
  endtask
  task automatic t_scale();
    send(`CMD_SCALE, 4'h0, 8'h81);
    chkb(top[0], 1'b1);
    chk(wp[0], 8'h5A);
    send(`CMD_SCALE, 4'h0, 8'h01);
    chk({6'h00, top[0], bot[0]}, 8'h01);
    send(`CMD_SCALE, 4'h0, 8'h00);
    chkb(bot[0], 1'b0);
    send(`CMD_SCALE, 4'h0, 8'h81);
    send(`CMD_STEP, 4'h0, 8'h01);
    chkb(top[0], 1'b0);
    send(`CMD_SCALE, 4'h0, 8'h81);
    send(`CMD_SHUTDOWN, 4'h0, 8'h01);
    chkb(top[0], 1'b0);
    chk({6'h00, shut[0], psw[0]}, 8'h03);
    chk(wp[0], 8'h5B);
    send(`CMD_WR_WIPER, 4'h0, 8'h77);
    chk(wp[0], 8'h77);
    send(`CMD_SHUTDOWN, 4'h0, 8'h00);
    chkb(shut[0], 1'b0);
    $display("t_scale done");
  endtask
  task automatic t_linear();
    send(`CMD_CONTROL, 4'h0, 8'h07);
    chk({3'h0, lin, ctl}, 8'h17);
    chk(wp[0], 8'h77);
    send(`CMD_WR_WIPER, 4'h4, 8'h44);
    chk(wp[1], 8'h44);
    send(`CMD_SHUTDOWN, 4'h4, 8'h01);
    chkb(hiz[1], 1'b1);
    send(`CMD_SHUTDOWN, 4'h4, 8'h00);
    send(`CMD_CONTROL, 4'h0, 8'h03);
    chkb(lin, 1'b0);
    ind_pin <= 1'b1;
    m.wt(6);
    chkb(lin, 1'b1);
    ind_pin <= 1'b0;
    m.wt(6);
    chkb(lin, 1'b0);
    $display("t_linear done");
  endtask
  task automatic t_protect();
    send(`CMD_CONTROL, 4'h0, 8'h02);
    send(`CMD_WR_WIPER, 4'h0, 8'h12);
    chk(wp[0], 8'h77);
    send(`CMD_STEP, 4'h0, 8'h01);
    chk(wp[0], 8'h77);
    send(`CMD_NV_COPY, 4'h0, 8'h00);
    chk(wp[0], `MIDSCALE);
    send(`CMD_CONTROL, 4'h0, 8'h0B);
    send(`CMD_WR_WIPER, 4'h0, 8'h10);
    send(`CMD_STEP, 4'h0, 8'h01, 3);
    chk(wp[0], 8'h13);
    send(`CMD_STEP, 4'h0, 8'h01, 2);
    chk(wp[0], 8'h15);
    send(`CMD_CONTROL, 4'h0, 8'h03);
    $display("t_protect done");
  endtask
  task automatic t_nv();
    send(`CMD_WR_WIPER, 4'h0, 8'h5A);
    send(`CMD_NV_COPY, 4'h0, 8'h01);
    chkb(busy, 1'b1);
    poll(dev_addr);
    chkb(ak, 1'b1);
    for (int i = 0; i < 400 && busy; i++) m.wt(1);
    poll(dev_addr);
    chkb(ak, 1'b0);
    send(`CMD_WR_WIPER, 4'h0, 8'h11);
    send(`CMD_SW_RESET, 4'h0, 8'h00);
    chk(wp[0], 8'h11);
    m.wt(760);
    chk(wp[0], 8'h5A);
    rd(4'h0, 8'h03, 8'h5A);
    send(`CMD_NV_WRITE, 4'h3, 8'h3C);
    chkb(busy, 1'b1);
    m.wt(220);
    rd(4'h3, 8'h01, 8'h3C);
    send(`CMD_CONTROL, 4'h0, 8'h01);
    send(`CMD_WR_WIPER, 4'h0, 8'h22);
    send(`CMD_NV_COPY, 4'h0, 8'h01);
    chkb(busy, 1'b0);
    send(`CMD_CONTROL, 4'h0, 8'h03);
    rst_n <= 1'b0;
    m.wt(4);
    rst_n <= 1'b1;
    m.wt(770);
    chk(wp[0], 8'h5A);
    $display("t_nv done");
  endtask
  // new strap address, then a mid-run reset with the mode pin high
  task automatic t_reset();
    dev_addr <= 7'h15;
    m.wt(4);
    poll(7'h2A);
    chkb(ak, 1'b1);
    send(`CMD_WR_WIPER, 4'h1, 8'h66);
    chk(wp[2], 8'h66);
    ind_pin <= 1'b1;
    srst <= 1'b1;
    m.wt(20);
    srst <= 1'b0;
    m.wt(4);
    chk(wp[2], `MIDSCALE);
    m.wt(760);
    chkb(lin, 1'b1);
    chk({4'h0, ctl}, {4'h0, `CTL_RESET});
    send(`CMD_WR_WIPER, 4'h5, 8'h21);
    chk(wp[3], 8'h21);
    $display("t_reset done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (760) @(posedge clk);
    t_power();
    t_shift();
    t_input();
    t_step();
    t_scale();
    t_linear();
    t_protect();
    t_nv();
    t_reset();
    results();
  end
endmodule
